// ==== inc/cap2_regs_cfg.svh ====
// Offsets, field positions and reset values of the capability-two and
// error reporting register slice. Definitions only.
`ifndef CAP2_REGS_CFG_SVH
`define CAP2_REGS_CFG_SVH

`define OFF_DEV_CAP2        12'h0e4
`define OFF_DEV_CTL2        12'h0e8
`define OFF_LINK_CAP2       12'h0ec
`define OFF_LINK_CTL2       12'h0f0
`define OFF_SLOT_CAP2       12'h0f4
`define OFF_SLOT_CTL2       12'h0f8
`define OFF_ERR_HDR         12'h100
`define OFF_ERR_STAT        12'h104

`define BIT_LTR_SUP         11
`define BIT_FC_LTR          12
`define LSB_OBFF_SUP        18
`define BIT_LTR_EN          10
`define LSB_OBFF_EN         13
`define BIT_DEEMP           6
`define BIT_CUR_DEEMP       16

`define ERR_HDR_ID          16'h0001
`define ERR_HDR_VER         4'h1
`define ERR_HDR_NEXT        12'h140

`define ERR_STAT_MASK       32'h003f_f011
`define SPEED_RESET         4'h2
`define LINK_CTL_WMASK      16'h1fbf

`endif

// ==== inc/cap2_regs_pkg.sv ====
// Types shared by the capability-two register slice.
// Assumes nothing beyond a SystemVerilog compiler.
package cap2_regs_pkg;
  typedef logic [31:0] word_t;
  typedef logic [11:0] cfg_addr_t;
endpackage

// ==== hdl/pcie_cap2_aer_status_regs.sv ====
// Configuration register slice of one switch port: capability-two group,
// error reporting header and uncorrectable error status.
// Assumes config requests arrive as one-cycle strobes synchronous to clk,
// and that sideband defaults are stable while rstn is low and at release.
// Functional notes
// - Device capability two bit 11 reads one
// - OBFF bits and FC LTR bit loadable
// - LTR enable and OBFF enable writable
// - De-emphasis select read-only, port-dependent default
// - Error header bits 15:0 read 0001h
// - Error header version reads 1h
// - Error header next pointer reads 140h
// - Training error sets status bit 0
// - Data link protocol error sets bit 4
// - Poisoned packet sets bit 12
// - Flow control protocol error sets bit 13
// - Completion timeout sets bit 14
// - Completer abort sets bit 15
// - Unexpected completion sets bit 16
// - Receiver overflow sets bit 17
// - Malformed packet sets bit 18
// - End-to-end CRC error sets bit 19
// - Unsupported request sets bit 20
// - Access control violation sets bit 21
`include "cap2_regs_cfg.svh"
`timescale 1ns/1ps
`default_nettype none

module pcie_cap2_aer_status_regs (
  input  wire logic                     clk,
  input  wire logic                     rstn,
  input  wire logic                     downstream_port,
  input  wire logic                     sb_load,
  input  wire logic                     sb_fc_ltr,
  input  wire logic [1:0]               sb_obff_sup,
  input  wire logic                     sb_deemp,
  input  wire logic                     cfg_rd,
  input  wire logic                     cfg_wr,
  input  wire cap2_regs_pkg::cfg_addr_t cfg_addr,
  input  wire cap2_regs_pkg::word_t     cfg_wdata,
  input  wire logic [3:0]               cfg_be,
  input  wire logic [21:0]              err_event,
  output var  cap2_regs_pkg::word_t     cfg_rdata,
  output var  logic                     cfg_rvalid,
  output var  logic                     ltr_enable,
  output var  logic [1:0]               obff_enable,
  output var  logic [3:0]               target_link_speed,
  output var  logic                     enter_compliance,
  output var  logic                     hardware_speed_change_disable,
  output var  logic                     deemphasis_select,
  output var  logic                     fatal_error_any
);

  // Sideband-loadable read-only defaults, reset-seen flag and current de-emphasis level
  logic                 fc_ltr;
  logic [1:0]           obff_sup;
  logic                 deemp;
  logic                 rst_seen;
  logic                 cur_deemp;
  // Writable link control and error status fields
  logic [15:0]          link_ctl;
  logic [21:0]          err_stat;

  // Byte-lane write masks built from the enables
  wire cap2_regs_pkg::word_t be_mask = {{8{cfg_be[3]}}, {8{cfg_be[2]}},
                                        {8{cfg_be[1]}}, {8{cfg_be[0]}}};
  wire cap2_regs_pkg::word_t wmasked = cfg_wdata & be_mask;

  wire hit_dev_ctl  = cfg_wr && (cfg_addr == `OFF_DEV_CTL2);
  wire hit_link_ctl = cfg_wr && (cfg_addr == `OFF_LINK_CTL2);
  wire hit_err_stat = cfg_wr && (cfg_addr == `OFF_ERR_STAT);

  // Only documented status positions exist; reserved bits read zero
  wire [21:0] stat_mask = 22'(`ERR_STAT_MASK);
  wire [21:0] clr_bits  = hit_err_stat ? wmasked[21:0] : 22'h00_0000;
  wire [21:0] set_bits  = err_event & stat_mask;
  // Set beats clear so an event arriving with the clear is kept
  wire [21:0] next_err_stat = ((err_stat & ~clr_bits) | set_bits)
                              & stat_mask;

  wire [15:0] link_wmask = `LINK_CTL_WMASK & be_mask[15:0];
  wire [15:0] next_link_ctl = (link_ctl & ~link_wmask)
                              | (wmasked[15:0] & link_wmask);

  // Read decode
  wire cap2_regs_pkg::word_t dev_cap_rd =
    (32'h0000_0001 << `BIT_LTR_SUP)
    | (32'(fc_ltr) << `BIT_FC_LTR)
    | (32'(obff_sup) << `LSB_OBFF_SUP);
  wire cap2_regs_pkg::word_t dev_ctl_rd =
    (32'(ltr_enable) << `BIT_LTR_EN)
    | (32'(obff_enable) << `LSB_OBFF_EN);
  wire cap2_regs_pkg::word_t link_ctl_rd =
    {16'h0000, link_ctl[15:7], deemp, link_ctl[5:0]}
    | (32'(cur_deemp) << `BIT_CUR_DEEMP);
  wire cap2_regs_pkg::word_t err_hdr_rd =
    {`ERR_HDR_NEXT, `ERR_HDR_VER, `ERR_HDR_ID};
  wire cap2_regs_pkg::word_t err_stat_rd = {10'h000, err_stat};

  cap2_regs_pkg::word_t next_rdata;
  always_comb begin
    if (cfg_addr == `OFF_DEV_CAP2) begin
      next_rdata = dev_cap_rd;
    end else if (cfg_addr == `OFF_DEV_CTL2) begin
      next_rdata = dev_ctl_rd;
    end else if (cfg_addr == `OFF_LINK_CTL2) begin
      next_rdata = link_ctl_rd;
    end else if (cfg_addr == `OFF_ERR_HDR) begin
      next_rdata = err_hdr_rd;
    end else if (cfg_addr == `OFF_ERR_STAT) begin
      next_rdata = err_stat_rd;
    end else begin
      // Link, slot capability two and slot control/status two read zero
      next_rdata = 32'h0000_0000;
    end
  end

  // The de-emphasis default is caught on the first clock after reset, not under reset,
  // and later reloaded on a sideband load strobe
  always_ff @(posedge clk) begin
    if (!rstn) begin
      rst_seen <= 1'b0;
      fc_ltr   <= 1'b0;
      obff_sup <= 2'b00;
      deemp    <= 1'b0;
    end else begin
      rst_seen <= 1'b1;
      if (!rst_seen) begin
        deemp <= downstream_port;
      end
      if (sb_load) begin
        fc_ltr   <= sb_fc_ltr;
        obff_sup <= sb_obff_sup;
        deemp    <= sb_deemp & downstream_port;
      end
    end
  end

  always_ff @(posedge clk) begin
    if (!rstn) begin
      ltr_enable  <= 1'b0;
      obff_enable <= 2'b00;
    end else if (hit_dev_ctl) begin
      if (cfg_be[1]) begin
        ltr_enable  <= cfg_wdata[`BIT_LTR_EN];
        obff_enable <= cfg_wdata[`LSB_OBFF_EN +: 2];
      end
    end
  end

  always_ff @(posedge clk) begin
    if (!rstn) begin
      link_ctl <= {12'h000, `SPEED_RESET};
    end else if (hit_link_ctl) begin
      link_ctl <= next_link_ctl;
    end
  end

  always_ff @(posedge clk) begin
    if (!rstn) begin
      err_stat <= 22'h00_0000;
    end else begin
      err_stat <= next_err_stat;
    end
  end

  always_ff @(posedge clk) begin
    if (!rstn) begin
      cfg_rdata  <= 32'h0000_0000;
      cfg_rvalid <= 1'b0;
      cur_deemp  <= 1'b0;
      target_link_speed <= `SPEED_RESET;
      enter_compliance  <= 1'b0;
      hardware_speed_change_disable <= 1'b0;
      deemphasis_select <= 1'b0;
      fatal_error_any   <= 1'b0;
    end else begin
      cfg_rdata  <= cfg_rd ? next_rdata : 32'h0000_0000;
      cfg_rvalid <= cfg_rd;
      // Current level follows the selected de-emphasis on this slice
      cur_deemp  <= deemp;
      target_link_speed <= link_ctl[3:0];
      enter_compliance  <= link_ctl[4];
      hardware_speed_change_disable <= link_ctl[5];
      deemphasis_select <= deemp;
      fatal_error_any   <= |err_stat;
    end
  end

endmodule

`default_nettype wire

// ==== test/rc_model.sv ====
// Root complex model: issues config reads and writes.
// Assumes the slice samples strobes on rising clk.
`timescale 1ns/1ps
`default_nettype none
module rc_model (
  input  wire logic        clk,
  input  wire logic [31:0] cfg_rdata,
  input  wire logic        cfg_rvalid,
  output var  logic        cfg_rd,
  output var  logic        cfg_wr,
  output var  logic [11:0] cfg_addr,
  output var  logic [31:0] cfg_wdata,
  output var  logic [3:0]  cfg_be
);
  initial {cfg_rd, cfg_wr, cfg_addr, cfg_wdata, cfg_be} = '0;
  task automatic wr(input logic [11:0] a, input logic [31:0] d);
    @(negedge clk);
    {cfg_wr, cfg_addr, cfg_wdata, cfg_be} = {1'b1, a, d, 4'hf};
    @(negedge clk);
    cfg_wr = 1'b0;
    // Released data must not keep the last value
    cfg_wdata = ~d;
  endtask
  task automatic rd(input logic [11:0] a, output logic [31:0] d);
    @(negedge clk);
    {cfg_rd, cfg_addr} = {1'b1, a};
    @(negedge clk);
    cfg_rd = 1'b0;
    d = cfg_rvalid ? cfg_rdata : 'x;
  endtask
endmodule
`default_nettype wire

// ==== test/pcie_cap2_aer_status_regs_sva.sv ====
// Checker for the register slice, bound to its ports.
// Assumes one clock and synchronous active-low reset.
`timescale 1ns/1ps
`default_nettype none
module regs_chk (
  input wire logic                     clk,
  input wire logic                     rstn,
  input wire logic                     cfg_rd,
  input wire cap2_regs_pkg::cfg_addr_t cfg_addr,
  input wire logic [21:0]              err_event,
  input wire cap2_regs_pkg::word_t     cfg_rdata,
  input wire logic                     fatal_error_any
);
  default clocking @(posedge clk); endclocking
  default disable iff (!rstn);
  wire rd_cap = cfg_rd && cfg_addr == 12'h0e4;
  wire rd_ctl = cfg_rd && cfg_addr == 12'h0e8;
  wire rd_lnk = cfg_rd && cfg_addr == 12'h0f0;
  wire rd_hdr = cfg_rd && cfg_addr == 12'h100;
  wire rd_sta = cfg_rd && cfg_addr == 12'h104;
  ltr_support_a: assert property (
    rd_cap |=> cfg_rdata[11:0] == 12'h800) else $error("ltr bit");
  cap_reserved_a: assert property (
    rd_cap |=> cfg_rdata[31:20] == 0 && cfg_rdata[17:13] == 0)
    else $error("cap reserved");
  ctl_reserved_a: assert property (
    rd_ctl |=> {cfg_rdata[31:15], cfg_rdata[12:11], cfg_rdata[9:0]} == 0)
    else $error("ctl reserved");
  deemph_mirror_a: assert property (
    rd_lnk |=> cfg_rdata[16] == cfg_rdata[6] && cfg_rdata[15:13] == 0)
    else $error("deemph");
  hdr_id_a: assert property (
    rd_hdr |=> cfg_rdata[15:0] == 16'h0001) else $error("hdr id");
  hdr_version_a: assert property (
    rd_hdr |=> cfg_rdata[19:16] == 4'h1) else $error("hdr version");
  hdr_next_a: assert property (
    rd_hdr |=> cfg_rdata[31:20] == 12'h140) else $error("hdr next");
  event_flag_a: assert property (
    (err_event & 22'h3f_f011) != 0 |-> ##[1:2] fatal_error_any)
    else $error("event lost");
  status_reserved_a: assert property (
    rd_sta |=> {cfg_rdata[31:22], cfg_rdata[11:5], cfg_rdata[3:1]} == 0)
    else $error("status reserved");
endmodule
bind pcie_cap2_aer_status_regs regs_chk i_regs_chk (.clk, .rstn, .cfg_rd,
  .cfg_addr, .err_event, .cfg_rdata, .fatal_error_any);
`default_nettype wire

// ==== test/tb_pcie_cap2_aer_status_regs.sv ====
// Self-checking bench for the register slice.
// Assumes the root model owns all config strobes.
`timescale 1ns/1ps
`default_nettype none
`define CHK(n, e, s) begin comparisons++; if ((s) !== (e)) begin \
  n_mismatch++; $display("ERROR %s exp %h got %h", n, e, s); end end
module tb_pcie_cap2_aer_status_regs;
  logic        clk = 0, rstn = 0, downstream_port = 1, sb_load = 0;
  logic        sb_fc_ltr = 0, sb_deemp = 0, cfg_rd, cfg_wr, cfg_rvalid;
  logic        ltr_enable, enter_compliance, hardware_speed_change_disable;
  logic        deemphasis_select, fatal_error_any;
  logic [1:0]  sb_obff_sup = 0, obff_enable;
  logic [3:0]  cfg_be, target_link_speed;
  logic [11:0] cfg_addr;
  logic [21:0] err_event = 0;
  logic [31:0] cfg_wdata, cfg_rdata, d;
  int          n_mismatch = 0, comparisons = 0;
  int          bits[12] = '{0, 4, 12, 13, 14, 15, 16, 17, 18, 19, 20, 21};
  pcie_cap2_aer_status_regs i_pcie_cap2_aer_status_regs (.*);
  rc_model i_rc_model (.*);
  task automatic chk_rd(input logic [11:0] a, input logic [31:0] e);
    i_rc_model.rd(a, d);
    `CHK($sformatf("reg %h", a), e, d)
  endtask
  task automatic t_reset;
    chk_rd(12'h0e4, 32'h0000_0800);
    chk_rd(12'h0e8, 32'h0000_0000);
    chk_rd(12'h0f0, 32'h0001_0042);
    chk_rd(12'h100, 32'h1401_0001);
    chk_rd(12'h108, 32'h0000_0000);
    chk_rd(12'h104, 32'h0000_0000);
    `CHK("deemph out", 1'b1, deemphasis_select)
    `CHK("speed out", 4'h2, target_link_speed)
  endtask
  task automatic t_sideband;
    @(negedge clk);
    {sb_load, sb_fc_ltr, sb_obff_sup, sb_deemp} = 5'b1_1110;
    @(negedge clk);
    sb_load = 0;
    chk_rd(12'h0e4, 32'h000c_1800);
    i_rc_model.wr(12'h0e4, 32'h0000_0000);
    i_rc_model.wr(12'h0f0, 32'h0000_0040);
    chk_rd(12'h0e4, 32'h000c_1800);
    chk_rd(12'h0f0, 32'h0000_0000);
  endtask
  task automatic t_ctl;
    i_rc_model.wr(12'h0e8, 32'hffff_ffff);
    chk_rd(12'h0e8, 32'h0000_6400);
    `CHK("ctl out", 3'b111, {ltr_enable, obff_enable})
    i_rc_model.wr(12'h0f0, 32'h0000_0035);
    @(negedge clk);
    `CHK("lnk out", 6'h35, {hardware_speed_change_disable, enter_compliance, target_link_speed})
    // Second reset mid-run, now as an upstream port
    @(negedge clk);
    {rstn, downstream_port} = 2'b00;
    repeat (4) @(negedge clk);
    rstn = 1;
    repeat (2) @(negedge clk);
    chk_rd(12'h0e4, 32'h0000_0800);
    chk_rd(12'h0e8, 32'h0000_0000);
    chk_rd(12'h0f0, 32'h0000_0002);
  endtask
  task automatic t_status;
    foreach (bits[i]) begin
      @(negedge clk);
      err_event[bits[i]] = 1'b1;
      @(negedge clk);
      err_event = '0;
      chk_rd(12'h104, 32'(1) << bits[i]);
      i_rc_model.wr(12'h104, 32'h0000_0000);
      chk_rd(12'h104, 32'(1) << bits[i]);
      `CHK("any", 1'b1, fatal_error_any)
      i_rc_model.wr(12'h104, 32'(1) << bits[i]);
      chk_rd(12'h104, 32'h0000_0000);
      `CHK("any clr", 1'b0, fatal_error_any)
    end
    @(negedge clk);
    err_event = 22'h00_0fee;
    @(negedge clk);
    err_event = '0;
    chk_rd(12'h104, 32'h0000_0000);
    // Event and clear in the same cycle: the event wins
    fork
      i_rc_model.wr(12'h104, 32'h0000_0010);
      begin
        @(negedge clk);
        err_event[4] = 1'b1;
        @(negedge clk);
        err_event = '0;
      end
    join
    chk_rd(12'h104, 32'h0000_0010);
  endtask
  task automatic summarize;
    $display("mismatches %0d of %0d checks", n_mismatch, comparisons);
    if (n_mismatch == 0 && comparisons > 0)
      $display("Testbench passed");
    else
      $display("Testbench failed");
    $finish;
  endtask
  initial forever #4 clk = ~clk;
  initial begin
    repeat (4) @(negedge clk);
    rstn = 1;
    repeat (2) @(negedge clk);
    t_reset;
    t_sideband;
    t_ctl;
    t_status;
    summarize;
  end
  initial begin
    #100000;
    n_mismatch++;
    summarize;
  end
endmodule
`default_nettype wire
